/* hdl/pmc_regs.sv */
// Power-management capability word and control/status word
module pmc_regs
  import pmc_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic hot_reset,
  input wire logic soft_reset,
  // Serial configuration memory load
  input wire logic mem_load,
  input wire logic [15:0] mem_cap_data,
  // Configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic cfg_ack,
  output logic [15:0] cfg_rdata,
  // Internal bus-configuration read port
  input wire logic bcr_rd,
  input wire logic [6:0] bcr_index,
  output logic bcr_ack,
  output logic [15:0] bcr_rdata,
  // Wake source and state
  input wire logic wake_event,
  input wire logic d3cold,
  output logic wake_out,
  output logic [1:0] power_state,
  output logic cap_loaded
);

  pmc_wake_if wif ();

  logic [15:0] cap_r;
  logic cap_loaded_r;
  pmc_pstate_t pstate_r;
  logic cfg_ack_r;
  logic [15:0] cfg_rdata_r;
  logic bcr_ack_r;
  logic [15:0] bcr_rdata_r;
  logic wake_out_r;
  logic [1:0] power_state_r;
  logic csr_wr;
  logic [1:0] req_state;
  logic state_ok;

  // Forces reserved bits to zero and the version to its fixed value
  function automatic logic [15:0] cap_clean(input logic [15:0] raw);
    cap_clean = (raw & ~(PMC_CAP_RSV_MASK | PMC_CAP_VER_MASK))
                | {13'h0000, PMC_VERSION};
  endfunction

  // Address match of one 16-bit word in configuration space
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  // Contents of the control/status word as seen on a read
  function automatic logic [15:0] csr_word(input logic st, input logic en,
                                           input pmc_pstate_t ps);
    logic [15:0] v;
    v = PMC_CSR_RESET;
    v[PMC_WSTAT_BIT] = st;
    v[PMC_WEN_BIT] = en;
    v[PMC_PSTATE_HI:PMC_PSTATE_LO] = ps;
    csr_word = v;
  endfunction

  // Capability word comes only from the memory load, no host write path
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cap_r <= PMC_CAP_RESET;
    else if (mem_load)
      cap_r <= cap_clean(mem_cap_data);
  end

  // Tells the rest of the device that the word holds memory contents
  // Stays high until the next power-on reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cap_loaded_r <= 1'b0;
    else if (mem_load)
      cap_loaded_r <= 1'b1;
  end

  // A write strobe aimed at the control/status word
  // Writes to the read-only capability word fall through unused
  assign csr_wr = cfg_wr && addr_hit(cfg_addr, PMC_CSR_OFFSET);
  assign req_state = cfg_wdata[PMC_PSTATE_HI:PMC_PSTATE_LO];

  // Unsupported D1 or D2 requests are ignored
  always_comb
  begin
    unique case (req_state)
      PMC_D1: state_ok = cap_r[PMC_D1_SUP_BIT];
      PMC_D2: state_ok = cap_r[PMC_D2_SUP_BIT];
      default: state_ok = 1'b1;
    endcase
  end

  // Power state returns to D0 on any reset
  // Hot and soft reset leave wake status and wake enable alone
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pstate_r <= PMC_D0;
    else if (hot_reset || soft_reset)
      pstate_r <= PMC_D0;
    else if (csr_wr && cfg_be[0] && state_ok)
      pstate_r <= pmc_pstate_t'(req_state);
  end

  // Wake keeper hookup
  assign wif.wake_event = wake_event;
  // Status and enable both sit in the upper byte lane
  assign wif.status_clear = csr_wr && cfg_be[1]
                            && cfg_wdata[PMC_WSTAT_BIT];
  assign wif.enable_wr = csr_wr && cfg_be[1];
  assign wif.enable_wdata = cfg_wdata[PMC_WEN_BIT];
  assign wif.d3cold = d3cold;
  assign wif.state = pstate_r;
  // Five support bits, one per state, D0 in the lowest
  assign wif.support_mask =
    cap_r[PMC_WAKE_SUP_HI:PMC_WAKE_SUP_LO];

  pmc_wake u_wake (
    .clk(clk),
    .resetn(resetn),
    .w(wif.wake)
  );

  // Configuration answer one cycle after the strobe
  // Every strobe is answered, ignored writes included
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cfg_ack_r <= 1'b0;
    else
      cfg_ack_r <= cfg_rd || cfg_wr;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cfg_rdata_r <= 16'h0000;
    else if (cfg_rd)
    begin
      // Unmapped words read as zero
      if (addr_hit(cfg_addr, PMC_CAP_OFFSET))
        cfg_rdata_r <= cap_r;
      else if (addr_hit(cfg_addr, PMC_CSR_OFFSET))
        cfg_rdata_r <= csr_word(wif.status, wif.enable, pstate_r);
      else
        cfg_rdata_r <= 16'h0000;
    end
    else
      cfg_rdata_r <= 16'h0000;
  end

  // Test alias reads the very same register
  // Other indices of the internal port live elsewhere and read zero here
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bcr_ack_r <= 1'b0;
    else
      bcr_ack_r <= bcr_rd;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bcr_rdata_r <= 16'h0000;
    else if (bcr_rd && bcr_index == PMC_ALIAS_INDEX)
      bcr_rdata_r <= cap_r;
    else
      bcr_rdata_r <= 16'h0000;
  end

  // Status outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wake_out_r <= 1'b0;
    else
      wake_out_r <= wif.pme;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      power_state_r <= PMC_D0;
    else
      power_state_r <= pstate_r;
  end

  // Every top output comes straight from its flop
  assign cfg_ack = cfg_ack_r;
  assign cfg_rdata = cfg_rdata_r;
  assign bcr_ack = bcr_ack_r;
  assign bcr_rdata = bcr_rdata_r;
  assign wake_out = wake_out_r;
  assign power_state = power_state_r;
  assign cap_loaded = cap_loaded_r;

endmodule

/* inc/pmc_pkg.sv */
// Constants for the power-management capability and control/status words
package pmc_pkg;

  // Configuration-space byte offsets of the 16-bit words
  localparam logic [7:0] PMC_CAP_OFFSET = 8'h42;
  localparam logic [7:0] PMC_CSR_OFFSET = 8'h44;

  // Internal bus-configuration register index of the test alias
  localparam logic [6:0] PMC_ALIAS_INDEX = 7'h24;

  // Capability word fields
  localparam int PMC_WAKE_SUP_HI = 15;
  localparam int PMC_WAKE_SUP_LO = 11;
  localparam int PMC_D2_SUP_BIT = 10;
  localparam int PMC_D1_SUP_BIT = 9;
  localparam int PMC_RSV_HI = 8;
  localparam int PMC_RSV_LO = 6;
  localparam int PMC_DSI_BIT = 5;
  localparam logic [2:0] PMC_VERSION = 3'h1;
  localparam logic [15:0] PMC_CAP_RESET = 16'h0001;
  localparam logic [15:0] PMC_CAP_RSV_MASK = 16'h01c0;
  localparam logic [15:0] PMC_CAP_VER_MASK = 16'h0007;

  // Control/status word fields
  localparam int PMC_WSTAT_BIT = 15;
  localparam int PMC_WEN_BIT = 8;
  localparam int PMC_PSTATE_HI = 1;
  localparam int PMC_PSTATE_LO = 0;
  localparam logic [15:0] PMC_CSR_RESET = 16'h0000;

  // Power states
  typedef enum logic [1:0] {
    PMC_D0 = 2'b00,
    PMC_D1 = 2'b01,
    PMC_D2 = 2'b10,
    PMC_D3 = 2'b11
  } pmc_pstate_t;

  // Wake-support bit positions inside the five-bit mask
  localparam int PMC_SUP_D0 = 0;
  localparam int PMC_SUP_D1 = 1;
  localparam int PMC_SUP_D2 = 2;
  localparam int PMC_SUP_D3HOT = 3;
  localparam int PMC_SUP_D3COLD = 4;

endpackage

/* inc/pmc_wake_if.sv */
// Signals between the register front end and the wake-status keeper
interface pmc_wake_if;
  import pmc_pkg::*;
  logic wake_event;
  logic status_clear;
  logic enable_wr;
  logic enable_wdata;
  logic d3cold;
  pmc_pstate_t state;
  logic [4:0] support_mask;
  logic status;
  logic enable;
  logic pme;

  modport ctrl (
    output wake_event, status_clear, enable_wr, enable_wdata, d3cold,
    output state, support_mask,
    input status, enable, pme
  );
  modport wake (
    input wake_event, status_clear, enable_wr, enable_wdata, d3cold,
    input state, support_mask,
    output status, enable, pme
  );
endinterface

/* hdl/pmc_wake.sv */
// Sticky wake-event status, wake enable and the wake output flop
module pmc_wake
  import pmc_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic resetn,
  // Front end
  pmc_wake_if.wake w
);

  logic status_r;
  logic enable_r;
  logic pme_r;
  logic allowed;

  // Support bit that belongs to the present power state
  always_comb
  begin
    unique case (w.state)
      PMC_D0: allowed = w.support_mask[PMC_SUP_D0];
      PMC_D1: allowed = w.support_mask[PMC_SUP_D1];
      PMC_D2: allowed = w.support_mask[PMC_SUP_D2];
      PMC_D3: allowed = w.d3cold ? w.support_mask[PMC_SUP_D3COLD]
                                 : w.support_mask[PMC_SUP_D3HOT];
    endcase
  end

  // Power-on reset and a status clear write clear it; an allowed event beats a clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      status_r <= 1'b0;
    else if (w.wake_event && allowed)
      status_r <= 1'b1;
    else if (w.status_clear)
      status_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      enable_r <= 1'b0;
    else if (w.enable_wr)
      enable_r <= w.enable_wdata;
  end

  // Output drops with the clear, the enable or a state without support
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pme_r <= 1'b0;
    else
      pme_r <= status_r && !w.status_clear && enable_r
               && allowed;
  end

  assign w.status = status_r;
  assign w.enable = enable_r;
  assign w.pme = pme_r;

endmodule

/* sim/pmc_regs_sva.sv */
// Port-level checks of the power-management register block
module pmc_regs_sva
  import pmc_pkg::*;
(
  // Clock, reset and requests
  input wire logic clk,
  input wire logic resetn,
  input wire logic mem_load,
  input wire logic [15:0] mem_cap_data,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  input wire logic bcr_rd,
  input wire logic [6:0] bcr_index,
  input wire logic wake_event,
  // Answers
  input wire logic cfg_ack,
  input wire logic [15:0] cfg_rdata,
  input wire logic [15:0] bcr_rdata,
  input wire logic wake_out,
  input wire logic [1:0] power_state
);
  logic [15:0] cap_r;
  logic en_r;
  logic cap_rd;
  logic st_wr;
  assign cap_rd = cfg_rd && cfg_addr == 8'h42;
  assign st_wr = cfg_wr && cfg_addr == 8'h44;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cap_r <= 16'h0001;
    else if (mem_load)
      cap_r <= (mem_cap_data & 16'hfe38) | 16'h0001;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      en_r <= 1'b0;
    else if (st_wr && cfg_be[1])
      en_r <= cfg_wdata[8];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_ack; (cfg_rd || cfg_wr) |=> cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_cap; cap_rd |=> cfg_rdata == $past(cap_r); endproperty
  a_cap: assert property (p_cap) else $error("cap word");
  property p_ver; cap_rd |=> cfg_rdata[2:0] == 3'b001; endproperty
  a_ver: assert property (p_ver) else $error("version");
  property p_rsv; cap_rd |=> cfg_rdata[8:6] == 3'b000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_alias;
    bcr_rd |=> bcr_rdata ==
      ($past(bcr_index) == 7'h24 ? $past(cap_r) : 16'h0000);
  endproperty
  a_alias: assert property (p_alias) else $error("alias");
  property p_en; $rose(wake_out) |-> $past(en_r, 2); endproperty
  a_en: assert property (p_en) else $error("wake off");
  property p_clr;
    st_wr && cfg_be[1] && cfg_wdata[15] && !wake_event &&
      !$past(wake_event) && !$past(wake_event, 2) |=> ##1 !wake_out;
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_ps;
    st_wr && cfg_be[0] && cfg_wdata[1:0] == 2'b00 |=> ##1 !power_state;
  endproperty
  a_ps: assert property (p_ps) else $error("state");
  c_wake: cover property ($rose(wake_out));
  c_alias: cover property (bcr_rd && bcr_index == 7'h24);
  c_load: cover property (mem_load);
endmodule
bind pmc_regs pmc_regs_sva sva_u (.*);

/* sim/pmc_host.sv */
// Host bridge model issuing configuration cycles
module pmc_host
(
  // Clock and answers
  input wire logic clk,
  input wire logic cfg_ack,
  input wire logic [15:0] cfg_rdata,
  // Requests
  output logic cfg_rd = 1'b0,
  output logic cfg_wr = 1'b0,
  output logic [7:0] cfg_addr = 8'h00,
  output logic [1:0] cfg_be = 2'b11,
  output logic [15:0] cfg_wdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [15:0] d, input logic [1:0] b, output logic [15:0] q);
    @(posedge clk);
    #1;
    cfg_rd = !w;
    cfg_wr = w;
    cfg_addr = a;
    cfg_be = b;
    cfg_wdata = a == 8'h42 ? d & 16'hfe3f : d;
    @(posedge clk);
    #1;
    // One-cycle strobe: the answer stands now, after the taking edge
    q = cfg_ack ? cfg_rdata : 16'hxxxx;
    {cfg_rd, cfg_wr} = 2'b00;
    // Released address and data lines stop showing the old value
    cfg_addr = ~a;
    cfg_wdata = ~cfg_wdata;
  endtask
endmodule

/* sim/tb.sv */
// Testbench for the power-management register block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, hot_reset = 0, soft_reset = 0;
  logic mem_load = 0, bcr_rd = 0, wake_event = 0, d3cold = 0;
  logic [15:0] mem_cap_data = 0, q, cfg_wdata, cfg_rdata, bcr_rdata;
  logic [6:0] bcr_index = 0;
  logic cfg_rd, cfg_wr, cfg_ack, bcr_ack, wake_out, cap_loaded;
  logic [7:0] cfg_addr;
  logic [1:0] cfg_be, power_state;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  initial
    forever #20 clk = ~clk;
  pmc_host host_u (.*);
  pmc_regs dut_u (.*);
  task automatic conclude(input int t);
    mismatches += t;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
      conclude(1);
  end
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host_u.xfer(1'b0, a, 16'h0000, 2'b11, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_u.xfer(1'b1, a, d, 2'b11, q);
  endtask
  task automatic wr_be(input logic [7:0] a, input logic [15:0] d,
    input logic [1:0] b);
    host_u.xfer(1'b1, a, d, b, q);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1;
    @(posedge clk);
    #1 s = 0;
  endtask
  task automatic alias_rd(input logic [6:0] i, input logic [15:0] e);
    bcr_index = i;
    pulse(bcr_rd);
    // Answer stands between the taking edge and the next one
    chk(bcr_ack ? bcr_rdata : 16'hxxxx, e);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1 resetn = 1;
    rd(8'h42, 16'h0001);
    wr(8'h42, 16'hffff);
    rd(8'h42, 16'h0001);
    mem_cap_data = 16'hffff;
    pulse(mem_load);
    rd(8'h42, 16'hfe39);
    alias_rd(7'h24, 16'hfe39);
    alias_rd(7'h23, 16'h0000);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h44, 16'(s));
      rd(8'h44, 16'(s));
      chk({14'h0, power_state}, 16'(s));
    end
    wr(8'h44, 16'h0103);
    pulse(wake_event);
    rd(8'h44, 16'h8103);
    chk({15'h0, wake_out}, 16'h0001);
    wr_be(8'h44, 16'h8000, 2'b01);
    rd(8'h44, 16'h8100);
    chk({15'h0, wake_out}, 16'h0001);
    wr(8'h44, 16'h8103);
    rd(8'h44, 16'h0103);
    chk({15'h0, wake_out}, 16'h0000);
    wr(8'h44, 16'h0003);
    pulse(wake_event);
    rd(8'h44, 16'h8003);
    chk({15'h0, wake_out}, 16'h0000);
    pulse(hot_reset);
    pulse(soft_reset);
    rd(8'h44, 16'h8000);
    mem_cap_data = 16'h0020;
    pulse(mem_load);
    rd(8'h42, 16'h0021);
    wr(8'h44, 16'h8001);
    rd(8'h44, 16'h0000);
    wr(8'h44, 16'h0002);
    rd(8'h44, 16'h0000);
    pulse(wake_event);
    rd(8'h44, 16'h0000);
    mem_cap_data = 16'h8000;
    pulse(mem_load);
    wr(8'h44, 16'h0003);
    d3cold = 1;
    pulse(wake_event);
    rd(8'h44, 16'h8003);
    resetn = 0;
    @(posedge clk);
    #1 resetn = 1;
    rd(8'h44, 16'h0000);
    conclude(0);
  end
endmodule
